// file: bench/hpp_host.sv
// Purpose: host model on the port pins, double or single strobe bus
// Assumes: pol_in bit set means that control pin is active high
// Notes: released data and select lines show the inverse of the last value; pin 8 idles high
`timescale 1ns/1ps
module hpp_host (
   input wire logic clk_in,
   input wire logic [10:0] pin_in,
   input wire logic [10:0] oe_in,
   input wire logic [2:0] pol_in,
   input wire logic tx_data_empty_flag_in,
   input wire logic rx_data_full_flag_in,
   input wire logic cmd_in,
   output hpp_pkg::hpp_pins_t pins_out
);
   import hpp_pkg::*;
   logic [10:0] drv = 11'h7ff;
   logic [2:0] ctl = 3'h7;
   logic [7:0] oe_seen = 8'h00;
   // single strobe: ctl 0 is read/write select, keep pol bit 0 clear then
   logic single = 1'b0;
   assign pins_out = {(oe_in & pin_in) | (~oe_in & drv), ctl ^ pol_in};
   // =====================================================
   // bus cycles
   task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk_in);
      drv <= {sel, d};
      ctl <= single ? {2'h0, !wr} : (wr ? 3'h1 : 3'h2);
      repeat (3) @(posedge clk_in);
      q = pins_out.io[7:0];
      oe_seen = oe_in[7:0];
      ctl <= 3'h7;
      // pin 8 idles high so a release never strobes a mux address
      drv <= {~sel[2:1], 1'b1, ~d};
      repeat (2) @(posedge clk_in);
   endtask : access
   // strobe is io 8, active low; a10 rides on the chip-select pin
   task automatic addr(input logic [10:0] a);
      @(posedge clk_in);
      drv <= {a[9:8], 1'b0, a[7:0]};
      ctl <= {a[10], 2'h3};
      @(posedge clk_in);
      drv[8] <= 1'b1;
   endtask : addr
   // waits for the flag that allows the access, gives up after 20 cycles
   task automatic xfer(input logic wr, input logic [2:0] sel, input logic [7:0] d,
         output logic [7:0] q, output logic ok);
      ok = 1'b0;
      q = 8'h00;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge clk_in);
         ok = wr ? ((sel == 3'h1) ? !cmd_in : tx_data_empty_flag_in) : (sel < 3'h5 || rx_data_full_flag_in);
      end
      if (ok) begin
         access(wr, sel, d, q);
      end
   endtask : xfer
endmodule : hpp_host

// file: bench/testbench.sv
// Purpose: self-checking bench of the parallel host port
// Assumes: host model on the pins, bench plays the dsp side
// Notes: the port may hold a word or two beside its fifo
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module testbench;
   import hpp_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic stop_in = 1'b0;
   hpp_ctrl_t ctrl = {HPP_MODE_NONMUX, 6'h20};
   logic [10:0] dir = 11'h000, gval = 11'h000, pout, poe, gin;
   logic [2:0] pol = 3'h0;
   hpp_pins_t pins;
   logic rx_data_full_flag, tx_data_empty_flag, cmd, txr, rxv, ack = 1'b0, txv = 1'b0, rxr = 1'b1;
   logic [6:0] vec;
   logic [23:0] txd = 24'h0, rxd;
   int num_errors = 0, checked = 0, cycles = 0;
   hpp_port hpp_port_i (.clk_in(clk_in), .rst_in(rst_in), .stop_in(stop_in),
      .port_control_in(ctrl), .pin_direction_in(dir), .gpio_value_in(gval),
      .pins_in(pins), .pin_out(pout), .pin_oe_out(poe), .gpio_in_value_out(gin),
      .rx_data_full_out(rx_data_full_flag), .tx_data_empty_out(tx_data_empty_flag), .host_command_out(cmd),
      .host_vector_out(vec), .dsp_cmd_ack_in(ack), .dsp_tx_valid_in(txv),
      .dsp_tx_data_in(txd), .dsp_tx_ready_out(txr), .dsp_rx_valid_out(rxv),
      .dsp_rx_data_out(rxd), .dsp_rx_ready_in(rxr));
   hpp_host hpp_host_i (.clk_in(clk_in), .pin_in(pout), .oe_in(poe), .pol_in(pol),
      .tx_data_empty_flag_in(tx_data_empty_flag), .rx_data_full_flag_in(rx_data_full_flag), .cmd_in(cmd), .pins_out(pins));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   // =====================================================
   // checking
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         num_errors++;
         complete_run;
      end
   end
   task automatic pulse_ack;
      ack <= 1'b1;
      @(posedge clk_in);
      ack <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk(cmd, 24'h0);
   endtask : pulse_ack
   // =====================================================
   // scenarios
   task automatic t_fill;
      logic ok;
      logic [7:0] q, n;
      int k;
      rxr <= 1'b0;
      ok = 1'b1;
      n = 8'h00;
      while (ok && n < 8'h08) begin
         hpp_host_i.xfer(1'b1, 3'h5, n, q, ok);
         if (ok) begin
            hpp_host_i.xfer(1'b1, 3'h6, ~n, q, ok);
            hpp_host_i.xfer(1'b1, 3'h7, n ^ 8'h5a, q, ok);
            n++;
         end
      end
      chk(poe, 24'h0);
      // fifo words, the dsp stage and the byte registers
      chk(n, `HPP_FIFO_DEPTH + 2);
      rxr <= 1'b1;
      k = 0;
      for (int c = 0; c < 60 && k < n; c++) begin
         @(posedge clk_in);
         if (rxv === 1'b1) begin
            chk(rxd, {k[7:0], ~k[7:0], k[7:0] ^ 8'h5a});
            k++;
         end
      end
      chk(k, n);
      repeat (3) @(posedge clk_in);
      chk({tx_data_empty_flag, rxv}, 24'h2);
   endtask : t_fill
   task automatic t_read;
      logic ok;
      logic [7:0] q;
      txd <= 24'h3c5a96;
      txv <= 1'b1;
      @(posedge clk_in);
      chk(txr, 24'h1);
      txv <= 1'b0;
      hpp_host_i.xfer(1'b0, 3'h5, 8'h00, q, ok);
      chk(q, 24'h3c);
      hpp_host_i.xfer(1'b0, 3'h6, 8'h00, q, ok);
      chk(q, 24'h5a);
      chk(rx_data_full_flag, 24'h1);
      hpp_host_i.xfer(1'b0, 3'h7, 8'h00, q, ok);
      chk(q, 24'h96);
      chk(hpp_host_i.oe_seen, 24'hff);
      chk({rx_data_full_flag, poe}, 24'h0);
   endtask : t_read
   task automatic t_cmd(input logic [2:0] p);
      logic ok;
      logic [7:0] q;
      pol <= p;
      ctrl.rd_high <= p[0];
      ctrl.wr_high <= p[1];
      ctrl.cs_high <= p[2];
      hpp_host_i.xfer(1'b1, 3'h1, 8'ha5, q, ok);
      chk({cmd, vec}, 24'ha5);
      hpp_host_i.access(1'b1, 3'h1, 8'h9e, q);
      chk({cmd, vec}, 24'ha5);
      hpp_host_i.xfer(1'b0, 3'h1, 8'h00, q, ok);
      chk(q, 24'ha5);
      hpp_host_i.xfer(1'b0, 3'h0, 8'h00, q, ok);
      chk(q, 24'h06);
      pulse_ack;
   endtask : t_cmd
   task automatic t_single;
      logic ok;
      logic [7:0] q;
      ctrl.double_strobe <= 1'b0;
      ctrl.ds_high <= 1'b1;
      pol <= 3'h2;
      hpp_host_i.single <= 1'b1;
      hpp_host_i.xfer(1'b1, 3'h1, 8'hb3, q, ok);
      chk({ok, cmd, vec}, 24'h1b3);
      hpp_host_i.xfer(1'b0, 3'h0, 8'h00, q, ok);
      chk(q, 24'h06);
      pulse_ack;
      hpp_host_i.single <= 1'b0;
      pol <= 3'h0;
      ctrl.double_strobe <= 1'b1;
      ctrl.ds_high <= 1'b0;
   endtask : t_single
   task automatic t_mux;
      logic [7:0] q;
      ctrl.mode <= HPP_MODE_MUX;
      for (int i = 0; i < 3; i++) begin
         hpp_host_i.addr((11'h100 << i) | 11'h001);
         hpp_host_i.access(1'b1, 3'h1, 8'h8f, q);
         chk(cmd, 24'h0);
      end
      hpp_host_i.addr(11'h001);
      hpp_host_i.access(1'b1, 3'h1, 8'h8f, q);
      chk({cmd, vec}, 24'h8f);
      hpp_host_i.addr(11'h000);
      hpp_host_i.access(1'b0, 3'h1, 8'h00, q);
      chk(q, 24'h06);
      pulse_ack;
   endtask : t_mux
   task automatic t_gpio;
      logic [7:0] q;
      ctrl.mode <= HPP_MODE_GPIO;
      dir <= 11'h5a3;
      gval <= 11'h3c6;
      hpp_host_i.access(1'b1, 3'h1, 8'h81, q);
      chk(cmd, 24'h0);
      chk(poe, 24'h5a3);
      chk(pout & 11'h5a3, 24'h182);
      chk(gin, 24'h3de);
      stop_in <= 1'b1;
      ctrl.mode <= HPP_MODE_NONMUX;
      hpp_host_i.access(1'b1, 3'h1, 8'h81, q);
      chk({cmd, poe}, 24'h0);
      chk(gin, 24'h3de);
      stop_in <= 1'b0;
   endtask : t_gpio
   // =====================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk_in);
      chk({tx_data_empty_flag, rx_data_full_flag, cmd, txr, rxv}, 24'h12);
      chk(poe, 24'h0);
      @(posedge clk_in);
      rst_in <= 1'b0;
      t_fill;
      t_read;
      t_cmd(3'h7);
      t_cmd(3'h0);
      t_single;
      t_mux;
      t_gpio;
      complete_run;
   end
endmodule : testbench

// file: verilog/hpp_cfg.svh
// Purpose: constants of the parallel host port
// Assumes: included by the package and the design file
// Notes: host register indices are three-bit selects
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH
// =====================================================
// widths
`define HPP_IO_W 11
`define HPP_WORD_W 24
`define HPP_VEC_W 7
`define HPP_FIFO_DEPTH 4
// =====================================================
// host register selects
`define HPP_SEL_STATUS 3'h0
`define HPP_SEL_VECTOR 3'h1
`define HPP_SEL_HIGH 3'h5
`define HPP_SEL_MIDDLE 3'h6
`define HPP_SEL_LOW 3'h7
// =====================================================
// field positions
`define HPP_ST_RX_DATA_FULL_FLAG_BIT 0
`define HPP_ST_TX_DATA_EMPTY_FLAG_BIT 1
`define HPP_ST_CMD_BIT 2
`define HPP_VEC_CMD_BIT 7
`define HPP_MUX_BASE 8'h00
`endif

// file: verilog/hpp_pkg.sv
// Purpose: types of the parallel host port
// Assumes: hpp_cfg.svh constants
// Notes: state of the top module is hpp_state_t
`include "hpp_cfg.svh"
package hpp_pkg;
   typedef enum logic [1:0] {HPP_MODE_GPIO, HPP_MODE_NONMUX, HPP_MODE_MUX} hpp_mode_t;

   // port control settings; polarity bits high mean active-high
   typedef struct packed {
      hpp_mode_t mode;
      logic double_strobe;
      logic as_high;
      logic ds_high;
      logic rd_high;
      logic wr_high;
      logic cs_high;
   } hpp_ctrl_t;

   // io: data lines 0-7 plus pins 8-10; ctl: rw/rd, ds/wr, cs/a10
   typedef struct packed {
      logic [`HPP_IO_W-1:0] io;
      logic [2:0] ctl;
   } hpp_pins_t;

   typedef struct packed {
      logic rx_data_full_flag;
      logic tx_empty;
      logic hc;
      logic tx_ready;
      logic rx_valid;
      logic [`HPP_VEC_W-1:0] vector;
      logic [`HPP_WORD_W-1:0] rx_word;
      logic [`HPP_WORD_W-1:0] tx_word;
      logic [`HPP_WORD_W-1:0] rx_out;
      logic [2:0] idx;
      logic [7:0] wdata;
      logic rd_q;
      logic wr_q;
      logic [10:0] mux_addr;
      logic [`HPP_IO_W-1:0] pin_out;
      logic [`HPP_IO_W-1:0] pin_oe;
      logic [`HPP_IO_W-1:0] gpio_in;
   } hpp_state_t;
endpackage : hpp_pkg

// file: verilog/hpp_port.sv
// Purpose: parallel host port pin logic, host flags and word paths
// Assumes: pins synchronous to clk_in; testbench resolves the wires
// Notes: host-to-dsp words pass a small fifo before the dsp receive register
`timescale 1ns/1ps
`include "hpp_cfg.svh"

// =====================================================
// fifo
module hpp_fifo #(
   parameter int WIDTH = `HPP_WORD_W,
   parameter int DEPTH = `HPP_FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } hpp_fifo_state_t;
   hpp_fifo_state_t s_reg;
   hpp_fifo_state_t s_next;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready_out = (s_reg.cnt != (PW+1)'(DEPTH));
   assign out_valid_out = (s_reg.cnt != '0);
   assign out_data_out = s_reg.mem[s_reg.rp];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wp] = in_data_in;
         s_next.wp = bump(s_reg.wp);
      end
      if (pop) begin
         s_next.rp = bump(s_reg.rp);
      end
      if (push && !pop) begin
         s_next.cnt = s_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : hpp_fifo

// =====================================================
// top
// Functional notes
// - transmit bytes move inward; empty flag sets
// - pending command presents a stable vector
// - port control selects every pin function
// - nonmux data bus driven only on reads
// - mux bus carries address then data
// - nonmux pins 8-10 select the register
// - mux pins 9-10 carry address 8, 9
// - mux pin 8 strobes address, polarity selectable
// - gpio pins follow their direction bits
// - reset and stop disconnect pin inputs
// - single strobe uses rw select plus strobe
// - double strobe uses separate read, write strobes
// - nonmux chip select qualifies every access
// - mux chip-select pin carries address 10
module hpp_port #(
   parameter logic [7:0] MUX_BASE = `HPP_MUX_BASE
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic stop_in,
   input wire hpp_pkg::hpp_ctrl_t port_control_in,
   input wire logic [`HPP_IO_W-1:0] pin_direction_in,
   input wire logic [`HPP_IO_W-1:0] gpio_value_in,
   input wire hpp_pkg::hpp_pins_t pins_in,
   output logic [`HPP_IO_W-1:0] pin_out,
   output logic [`HPP_IO_W-1:0] pin_oe_out,
   output logic [`HPP_IO_W-1:0] gpio_in_value_out,
   output logic rx_data_full_out,
   output logic tx_data_empty_out,
   output logic host_command_out,
   output logic [`HPP_VEC_W-1:0] host_vector_out,
   input wire logic dsp_cmd_ack_in,
   input wire logic dsp_tx_valid_in,
   input wire logic [`HPP_WORD_W-1:0] dsp_tx_data_in,
   output logic dsp_tx_ready_out,
   output logic dsp_rx_valid_out,
   output logic [`HPP_WORD_W-1:0] dsp_rx_data_out,
   input wire logic dsp_rx_ready_in
);
   import hpp_pkg::*;

   hpp_state_t s_reg;
   hpp_state_t s_next;
   logic live;
   logic host_mode;
   logic [`HPP_IO_W-1:0] io;
   logic [2:0] ctl;
   logic as_act;
   logic cs_act;
   logic rd_act;
   logic wr_act;
   logic sel;
   logic [2:0] idx;
   logic [2:0] cur_idx;
   logic acc_rd;
   logic acc_wr;
   logic wr_end;
   logic rd_end;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [`HPP_WORD_W-1:0] fifo_out_data;
   logic push;
   logic [10:0] mux_pick;

   function automatic logic act(input logic pin, input logic high);
      act = high ? pin : !pin;
   endfunction : act

   function automatic logic [7:0] read_mux(input logic [2:0] i, input hpp_state_t s);
      logic [7:0] st;
      st = '0;
      st[`HPP_ST_RX_DATA_FULL_FLAG_BIT] = s.rx_data_full_flag;
      st[`HPP_ST_TX_DATA_EMPTY_FLAG_BIT] = s.tx_empty;
      st[`HPP_ST_CMD_BIT] = s.hc;
      case (i)
         `HPP_SEL_STATUS: read_mux = st;
         `HPP_SEL_VECTOR: read_mux = {s.hc, s.vector};
         `HPP_SEL_HIGH: read_mux = s.rx_word[23:16];
         `HPP_SEL_MIDDLE: read_mux = s.rx_word[15:8];
         `HPP_SEL_LOW: read_mux = s.rx_word[7:0];
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   hpp_fifo #(.WIDTH(`HPP_WORD_W), .DEPTH(`HPP_FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(s_reg.tx_empty == 1'b0),
      .in_ready_out(fifo_in_ready),
      .in_data_in(s_reg.tx_word),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_out_ready),
      .out_data_out(fifo_out_data)
   );

   // =====================================================
   // pin decode
   always_comb begin
      live = !stop_in && !rst_in;
      io = live ? pins_in.io : '0;
      ctl = live ? pins_in.ctl : '0;
      host_mode = (port_control_in.mode != HPP_MODE_GPIO);
      // pin 8 is address bit 0 in nonmux mode, so it must never block an access there
      as_act = (port_control_in.mode == HPP_MODE_MUX) && live
         && act(io[8], port_control_in.as_high);
      mux_pick = {ctl[2], io[10], io[9], io[7:0]};
      cs_act = act(ctl[2], port_control_in.cs_high);
      if (port_control_in.double_strobe) begin
         rd_act = act(ctl[0], port_control_in.rd_high);
         wr_act = act(ctl[1], port_control_in.wr_high);
      end else begin
         rd_act = act(ctl[1], port_control_in.ds_high) && ctl[0];
         wr_act = act(ctl[1], port_control_in.ds_high) && !ctl[0];
      end
      if (port_control_in.mode == HPP_MODE_MUX) begin
         sel = (s_reg.mux_addr[10:3] == MUX_BASE);
         idx = s_reg.mux_addr[2:0];
      end else begin
         sel = cs_act;
         idx = io[10:8];
      end
      acc_rd = live && host_mode && sel && rd_act && !as_act;
      acc_wr = live && host_mode && sel && wr_act && !as_act;
      cur_idx = (s_reg.rd_q || s_reg.wr_q) ? s_reg.idx : idx;
      wr_end = host_mode && s_reg.wr_q && !acc_wr;
      rd_end = host_mode && s_reg.rd_q && !acc_rd;
      fifo_out_ready = !s_reg.rx_valid || dsp_rx_ready_in;
      push = !s_reg.tx_empty && fifo_in_ready;
   end

   // =====================================================
   // next state
   always_comb begin
      s_next = s_reg;
      s_next.rd_q = acc_rd;
      s_next.wr_q = acc_wr;
      s_next.idx = cur_idx;
      if (acc_wr) begin
         s_next.wdata = io[7:0];
      end
      if (as_act) begin
         s_next.mux_addr = mux_pick;
      end
      if (live) begin
         s_next.gpio_in = io;
      end
      // inward move frees the byte registers; a new low write still wins
      if (push) begin
         s_next.tx_empty = 1'b1;
      end
      if (wr_end) begin
         case (s_reg.idx)
            `HPP_SEL_HIGH: s_next.tx_word[23:16] = s_reg.wdata;
            `HPP_SEL_MIDDLE: s_next.tx_word[15:8] = s_reg.wdata;
            `HPP_SEL_LOW: begin
               s_next.tx_word[7:0] = s_reg.wdata;
               s_next.tx_empty = 1'b0;
            end
            `HPP_SEL_VECTOR: begin
               // a vector write during a pending command is dropped
               if (!s_reg.hc) begin
                  s_next.vector = s_reg.wdata[`HPP_VEC_W-1:0];
                  s_next.hc = s_reg.wdata[`HPP_VEC_CMD_BIT];
               end
            end
            default: s_next.idx = s_reg.idx;
         endcase
      end
      if (dsp_cmd_ack_in && s_reg.hc) begin
         s_next.hc = 1'b0;
      end
      // load only while empty, so a read clear can never race a load
      if (rd_end && s_reg.idx == `HPP_SEL_LOW && s_reg.rx_data_full_flag) begin
         s_next.rx_data_full_flag = 1'b0;
      end else if (!s_reg.rx_data_full_flag && dsp_tx_valid_in) begin
         s_next.rx_word = dsp_tx_data_in;
         s_next.rx_data_full_flag = 1'b1;
      end
      s_next.tx_ready = !s_next.rx_data_full_flag;
      if (fifo_out_ready) begin
         s_next.rx_valid = fifo_out_valid;
         if (fifo_out_valid) begin
            s_next.rx_out = fifo_out_data;
         end
      end
      if (!live) begin
         s_next.pin_oe = '0;
         s_next.pin_out = '0;
      end else if (host_mode) begin
         s_next.pin_out = {3'h0, read_mux(cur_idx, s_reg)};
         s_next.pin_oe = {3'h0, {8{acc_rd}}};
      end else begin
         s_next.pin_out = gpio_value_in;
         s_next.pin_oe = pin_direction_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg <= '0;
         s_reg.tx_empty <= 1'b1;
         s_reg.tx_ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pin_out = s_reg.pin_out;
   assign pin_oe_out = s_reg.pin_oe;
   assign gpio_in_value_out = s_reg.gpio_in;
   assign rx_data_full_out = s_reg.rx_data_full_flag;
   assign tx_data_empty_out = s_reg.tx_empty;
   assign host_command_out = s_reg.hc;
   assign host_vector_out = s_reg.vector;
   assign dsp_tx_ready_out = s_reg.tx_ready;
   assign dsp_rx_valid_out = s_reg.rx_valid;
   assign dsp_rx_data_out = s_reg.rx_out;

   // =====================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   tx_empty_set_a: assert property (push && !wr_end |=> tx_data_empty_out)
      else $error("empty flag not set after inward move");
   tx_empty_clr_a: assert property (wr_end && s_reg.idx == `HPP_SEL_LOW |=>
      !tx_data_empty_out)
      else $error("empty flag not cleared by low write");
   vector_stable_a: assert property (host_command_out |=> $stable(host_vector_out))
      else $error("vector moved while command pending");
   read_drive_a: assert property ($past(host_mode) && pin_oe_out[7:0] != 8'h00 |->
      $past(acc_rd))
      else $error("data bus driven outside a read");
   gpio_dir_a: assert property (!host_mode && live |=>
      pin_oe_out == $past(pin_direction_in))
      else $error("gpio enable does not follow direction");
   stop_quiet_a: assert property (stop_in |=>
      pin_oe_out == '0 && !s_reg.rd_q && !s_reg.wr_q)
      else $error("pins active during stop");
   gpio_ignore_a: assert property (!host_mode |=>
      $stable(host_vector_out) && !$fell(tx_data_empty_out))
      else $error("host state changed in gpio mode");
   cs_qualify_a: assert property (port_control_in.mode == HPP_MODE_NONMUX && !cs_act |->
      !acc_rd && !acc_wr)
      else $error("access without chip select");
   mux_latch_a: assert property (as_act |=> s_reg.mux_addr == $past(mux_pick))
      else $error("address strobe did not latch address");
   rx_clear_a: assert property (rd_end && s_reg.idx == `HPP_SEL_LOW && rx_data_full_out |=>
      !rx_data_full_out && dsp_tx_ready_out)
      else $error("low byte read did not free receive bytes");

   word_in_c: cover property (push ##[1:8] dsp_rx_valid_out);
   word_out_c: cover property (rx_data_full_out ##[1:40] !rx_data_full_out);
   command_c: cover property ($rose(host_command_out) ##[1:20] $fell(host_command_out));
   fifo_full_c: cover property (!fifo_in_ready && !tx_data_empty_out);
endmodule : hpp_port
